// ---- hif_regs.sv ----
// host register group: mask, byte test, fifo thresholds, receive config
`timescale 1ns/100ps
module hif_regs
    import hif_pkg::*;
#(
    parameter int CNT_W = 12
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // status sources from the rest of the controller (one-cycle or level)
    input wire logic [31:0] source_event_i,
    input wire hif_levels_type levels_i,
    input wire logic rx_dword_read_i,
    input wire logic rx_packet_start_i,
    // to the receive datapath
    output hif_rxcfg_type rxcfg_o,
    output logic [4:0] active_offset_o,
    output logic [2:0] pad_dwords_o,
    // host interrupt
    output logic irq_o
);
    initial begin
        if (CNT_W != 12) $error("countdown field is 12 bits wide");
    end

    // ************************************************************************
    // bus decode
    // ************************************************************************
    wire access = psel_i && penable_i;
    wire wr = access && pwrite_i;
    wire hit_sts = paddr_i == HIF_ADDR_STATUS;
    wire hit_en = paddr_i == HIF_ADDR_MASK;
    wire hit_clr = paddr_i == HIF_ADDR_INT_CLR;
    wire hit_bt = paddr_i == HIF_ADDR_ORDER;
    wire hit_thr = paddr_i == HIF_ADDR_FIFO_THR;
    wire hit_rx = paddr_i == HIF_ADDR_RXCONF;
    wire hit_any = hit_sts | hit_en | hit_clr | hit_bt | hit_thr | hit_rx;
    wire wr_en = wr && hit_en;
    wire wr_thr = wr && hit_thr;
    wire wr_rx = wr && hit_rx;
    wire wr_clr = wr && hit_clr;

    // single-cycle access phase: never waits
    assign pready_o = 1'b1;
    // unmapped address, or a write to a read-only word, is an error
    assign pslverr_o = access && (!hit_any || (pwrite_i && (hit_sts || hit_bt)));

    // ************************************************************************
    // registers
    // ************************************************************************
    logic [31:0] int_enable;     // interrupt_enable_mask
    logic [7:0] tx_avail_thr;    // 64-byte blocks
    logic [7:0] tx_stat_thr;     // doublewords
    logic [7:0] rx_stat_thr;     // doublewords
    logic [1:0] align;           // end alignment
    logic [4:0] start_offset;    // programmed offset
    logic [2:0] dw_offset_live;  // upper offset bits as used by the datapath
    logic purge;                 // self clearing

    // mask bits; reserved positions never store
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            int_enable <= '0;
        end else if (wr_en) begin
            int_enable <= pwdata_i & HIF_MASK_WRITABLE;
        end
    end

    // level thresholds
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            tx_avail_thr <= HIF_TXA_RST;
            tx_stat_thr <= HIF_TSL_RST;
            rx_stat_thr <= HIF_RSL_RST;
        end else if (wr_thr) begin
            tx_avail_thr <= pwdata_i[HIF_TXA_LSB +: 8];
            tx_stat_thr <= pwdata_i[HIF_TSL_LSB +: 8];
            rx_stat_thr <= pwdata_i[HIF_RSL_LSB +: 8];
        end
    end

    // receive configuration; purge lives for exactly one cycle
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            align <= HIF_ALIGN_4;
            start_offset <= '0;
            purge <= 1'b0;
        end else begin
            purge <= wr_rx && pwdata_i[HIF_PURGE_BIT];
            if (wr_rx) begin
                align <= pwdata_i[HIF_ALIGN_LSB +: 2];
                start_offset <= pwdata_i[HIF_OFF_LSB +: 5];
            end
        end
    end

    // upper offset bits reach the datapath only on a doubleword read or a packet start
    // so a change mid-stream never splits a word
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            dw_offset_live <= '0;
        end else if (rx_dword_read_i || rx_packet_start_i) begin
            dw_offset_live <= start_offset[4:2];
        end
    end

    // low bits are used directly; the host keeps them still while running
    assign active_offset_o = {dw_offset_live, start_offset[1:0]};
    assign rxcfg_o = '{align: align, start_offset: start_offset, purge: purge};

    // ************************************************************************
    // end alignment padding
    // ************************************************************************
    // doublewords of pad after a final word ending at word index level_i
    // taken from the low bits of the receive status level as word count
    wire [2:0] words_mod = levels_i.rx_status_used[2:0];
    // pad is the negated word count modulo the words per boundary;
    // three bits because a 32-byte boundary can need up to seven words
    logic [2:0] pad_calc;
    always_comb begin
        pad_calc = 3'd0;
        unique case (align)
            HIF_ALIGN_4: pad_calc = 3'd0;
            HIF_ALIGN_16: pad_calc = {1'b0, 2'd0 - words_mod[1:0]};
            HIF_ALIGN_32: pad_calc = 3'd0 - words_mod;
            HIF_ALIGN_RSV: pad_calc = 3'd0;
        endcase
    end
    // limitation: pad count is a hint; the datapath appends the words
    assign pad_dwords_o = pad_calc;

    // ************************************************************************
    // countdown
    // ************************************************************************
    logic [CNT_W-1:0] count;
    logic count_done;
    hif_rxcount #(
        .CNT_W(CNT_W)
    ) u_count (
        .clk_sys_i(clk_sys_i),
        .reset_n_i(reset_n_i),
        .load_i(wr_rx),
        .load_val_i(pwdata_i[HIF_CNT_LSB +: CNT_W]),
        .dword_read_i(rx_dword_read_i),
        .count_o(count),
        .done_o(count_done)
    );

    // ************************************************************************
    // level comparisons
    // ************************************************************************
    wire [15:0] txa_bytes = 16'(tx_avail_thr) * 16'(HIF_TXA_BLOCK_BYTES);
    wire lvl_txa = levels_i.tx_free_bytes > txa_bytes;
    wire lvl_tsl = levels_i.tx_status_used > tx_stat_thr;
    wire lvl_rsl = levels_i.rx_status_used > rx_stat_thr;

    // ************************************************************************
    // interrupt status
    // ************************************************************************
    logic [31:0] events;
    always_comb begin
        events = source_event_i;
        events[HIF_ST_TXA] = source_event_i[HIF_ST_TXA] | lvl_txa;
        events[HIF_ST_TSL] = source_event_i[HIF_ST_TSL] | lvl_tsl;
        events[HIF_ST_RSL] = source_event_i[HIF_ST_RSL] | lvl_rsl;
        events[HIF_ST_RXD] = source_event_i[HIF_ST_RXD] | count_done;
    end

    logic [31:0] status;
    hif_irq #(
        .WIDTH(32)
    ) u_irq (
        .clk_sys_i(clk_sys_i),
        .reset_n_i(reset_n_i),
        .event_i(events & HIF_MASK_WRITABLE),
        .clear_i(wr_clr ? pwdata_i : 32'h0000_0000),
        .enable_i(int_enable),
        .status_o(status),
        .irq_o(irq_o)
    );

    // ************************************************************************
    // read data
    // ************************************************************************
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (hit_sts) rd_mux = status;
        if (hit_en) rd_mux = int_enable;
        if (hit_bt) rd_mux = HIF_ORDER_PATTERN;
        if (hit_thr) rd_mux = {tx_avail_thr, tx_stat_thr, 8'h00, rx_stat_thr};
        if (hit_rx) rd_mux = {align, 2'b00, count, 1'b0, 2'b00, start_offset, 8'h00};
    end

    // read data registered at the setup phase so it stands in the access phase
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            prdata_o <= '0;
        end else if (psel_i && !penable_i && !pwrite_i) begin
            prdata_o <= rd_mux;
        end
    end
endmodule : hif_regs

// ---- hif_pkg.sv ----
// package of register map, field layout and carrier types for the host register group
// ****************************************************************************
// Behaviour
// - set enable bit routes status to interrupt
// - status tracks sources regardless of enable
// - mask bits 31,25,24,23; 30:26,22 reserved
// - mask bits 21 down to 16 enables
// - mask bits 15..0 enables; 12:11,5 reserved
// - byte test register returns fixed pattern
// - tx space irq when free exceeds threshold
// - tx status level irq above threshold
// - rx status level irq above threshold
// - pad last transfer to end alignment
// - alignment codes 4, 16, 32 bytes
// - countdown decrements per read doubleword
// - countdown write replaces current count
// - purge bit empties rx fifos, self clears
// - start offset shifts packet data 0-31
// - upper offset bits apply next read
// ****************************************************************************
package hif_pkg;

    // ************************************************************************
    // register byte addresses
    // ************************************************************************
    localparam logic [7:0] HIF_ADDR_STATUS = 8'h58;   // status, read only
    localparam logic [7:0] HIF_ADDR_MASK = 8'h5c;
    localparam logic [7:0] HIF_ADDR_INT_CLR = 8'h60;   // clear, write only
    localparam logic [7:0] HIF_ADDR_ORDER = 8'h64;
    localparam logic [7:0] HIF_ADDR_FIFO_THR = 8'h68;
    localparam logic [7:0] HIF_ADDR_RXCONF = 8'h6c;

    // ************************************************************************
    // field layout and reset values
    // ************************************************************************
    // writable mask bits; 30:26, 22, 12:11 and 5 are reserved
    localparam logic [31:0] HIF_MASK_WRITABLE = 32'h83bf_e7df;
    localparam logic [31:0] HIF_ORDER_PATTERN = 32'h8765_4321;
    localparam int HIF_TXA_LSB = 24;
    localparam int HIF_TSL_LSB = 16;
    localparam int HIF_RSL_LSB = 0;
    localparam logic [7:0] HIF_TXA_RST = 8'h48;
    localparam logic [7:0] HIF_TSL_RST = 8'h00;
    localparam logic [7:0] HIF_RSL_RST = 8'h00;
    localparam int HIF_ALIGN_LSB = 30;
    localparam int HIF_CNT_LSB = 16;
    localparam int HIF_PURGE_BIT = 15;
    localparam int HIF_OFF_LSB = 8;
    localparam int HIF_TXA_BLOCK_BYTES = 64;  // threshold unit of the tx space field
    // status bit positions of the level and countdown sources produced here
    localparam int HIF_ST_RXD = 20;
    localparam int HIF_ST_TXA = 9;
    localparam int HIF_ST_TSL = 7;
    localparam int HIF_ST_RSL = 3;

    // end alignment codes
    typedef enum logic [1:0] {
        HIF_ALIGN_4 = 2'b00,
        HIF_ALIGN_16 = 2'b01,
        HIF_ALIGN_32 = 2'b10,
        HIF_ALIGN_RSV = 2'b11
    } hif_align_type;

    // fifo levels reported by the datapath
    typedef struct packed {
        logic [15:0] tx_free_bytes;
        logic [7:0] tx_status_used;
        logic [7:0] rx_status_used;
    } hif_levels_type;

    // receive configuration handed to the datapath
    typedef struct packed {
        logic [1:0] align;
        logic [4:0] start_offset;
        logic purge;
    } hif_rxcfg_type;

endpackage : hif_pkg

// ---- hif_irq.sv ----
// sticky interrupt status with enable mask and one level output
`timescale 1ns/100ps
module hif_irq
    import hif_pkg::*;
#(
    parameter int WIDTH = 32
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    // events and software access
    input wire logic [WIDTH-1:0] event_i,
    input wire logic [WIDTH-1:0] clear_i,
    input wire logic [WIDTH-1:0] enable_i,
    // results
    output logic [WIDTH-1:0] status_o,
    output logic irq_o
);
    initial begin
        if (WIDTH < 1) $error("width must be positive");
    end

    // ************************************************************************
    // sticky status
    // ************************************************************************
    // set beats clear so an event in the clearing cycle stays seen
    logic [WIDTH-1:0] next_status;
    assign next_status = (status_o & ~clear_i) | event_i;

    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            status_o <= '0;
        end else begin
            status_o <= next_status;
        end
    end

    // combinational so the pin follows the mask at once
    assign irq_o = |(status_o & enable_i);
endmodule : hif_irq

// ---- hif_rxcount.sv ----
// receive countdown: decrements per doubleword read, fires at zero
`timescale 1ns/100ps
module hif_rxcount
    import hif_pkg::*;
#(
    parameter int CNT_W = 12
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    // control
    input wire logic load_i,
    input wire logic [CNT_W-1:0] load_val_i,
    input wire logic dword_read_i,
    // state
    output logic [CNT_W-1:0] count_o,
    output logic done_o
);
    initial begin
        if (CNT_W < 1 || CNT_W > 16) $error("count width out of range");
    end

    // ************************************************************************
    // counter
    // ************************************************************************
    wire dec_now = dword_read_i && (count_o != '0);
    wire hit_zero = dec_now && (count_o == CNT_W'(1));

    // a write wins over a same-cycle read; the new count is fresh
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            count_o <= '0;
            done_o <= 1'b0;
        end else begin
            done_o <= hit_zero && !load_i;
            if (load_i) begin
                count_o <= load_val_i;
            end else if (dec_now) begin
                count_o <= count_o - CNT_W'(1);
            end
        end
    end
endmodule : hif_rxcount

// ---- hif_regs_properties.sv ----
// checker of the host register group port behaviour
`timescale 1ns/100ps
module hif_regs_properties
    import hif_pkg::*;
#(
    parameter int CNT_W = 12
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    // receive side
    input wire logic rx_dword_read_i,
    input wire hif_rxcfg_type rxcfg_o,
    input wire logic [4:0] active_offset_o,
    input wire logic irq_o
);
    // ************************************************************************
    // decode of bus phases
    // ************************************************************************
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!reset_n_i);
    wire acc = psel_i & penable_i;  // access phase
    wire wr_cfg = acc & pwrite_i & (paddr_i == HIF_ADDR_RXCONF);
    wire bad = (pwrite_i & (paddr_i == HIF_ADDR_ORDER)) | (paddr_i == 8'h00);
    // purge is a single-cycle pulse, never a level
    sequence s_purge_pulse;
        rxcfg_o.purge ##1 !rxcfg_o.purge;
    endsequence
    property p_ready; acc |-> pready_o; endproperty
    property p_refuse; acc && bad |-> pslverr_o; endproperty
    property p_test_read;
        psel_i && !penable_i && !pwrite_i && paddr_i == HIF_ADDR_ORDER
            |=> prdata_o == HIF_ORDER_PATTERN;
    endproperty
    property p_purge; wr_cfg && pwdata_i[15] |=> s_purge_pulse; endproperty
    property p_align; wr_cfg |=> rxcfg_o.align == $past(pwdata_i[31:30]); endproperty
    property p_offset; wr_cfg |=> rxcfg_o.start_offset == $past(pwdata_i[12:8]); endproperty
    property p_upper;
        rx_dword_read_i && !wr_cfg |=> active_offset_o[4:2] == $past(rxcfg_o.start_offset[4:2]);
    endproperty
    property p_mask_off;
        acc && pwrite_i && paddr_i == HIF_ADDR_MASK && pwdata_i == 32'h0 |=> !irq_o;
    endproperty
    a_ready: assert property (p_ready) else $error("access without ready");
    a_refuse: assert property (p_refuse) else $error("refused access without error");
    a_test_read: assert property (p_test_read) else $error("byte test pattern wrong");
    a_purge: assert property (p_purge) else $error("purge pulse wrong");
    a_align: assert property (p_align) else $error("alignment not stored");
    a_offset: assert property (p_offset) else $error("start offset not stored");
    a_upper: assert property (p_upper) else $error("upper offset not applied");
    a_mask_off: assert property (p_mask_off) else $error("irq with mask cleared");
endmodule : hif_regs_properties
bind hif_regs hif_regs_properties #(.CNT_W(CNT_W)) chk_u (.clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .rx_dword_read_i(rx_dword_read_i), .rxcfg_o(rxcfg_o),
    .active_offset_o(active_offset_o), .irq_o(irq_o));

// ---- hif_host_model.sv ----
// host processor model: apb master issuing whole-word transfers
`timescale 1ns/100ps
module hif_host_model (
    // clock
    input wire logic clk_sys_i,
    // apb master side
    output logic psel_o,
    output logic penable_o,
    output logic pwrite_o,
    output logic [7:0] paddr_o,
    output logic [31:0] pwdata_o,
    input wire logic [31:0] prdata_i,
    input wire logic pready_i
);
    initial begin
        psel_o = 1'b0;
        penable_o = 1'b0;
        pwrite_o = 1'b0;
        paddr_o = 8'h00;
        pwdata_o = 32'h0;
    end
    // setup, then access held until ready is sampled; no assumed latency
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        @(posedge clk_sys_i);
        psel_o <= 1'b1;
        pwrite_o <= wr;
        paddr_o <= a;
        pwdata_o <= d;
        @(posedge clk_sys_i);
        penable_o <= 1'b1;
        do @(posedge clk_sys_i); while (pready_i !== 1'b1);
        q = prdata_i;
        psel_o <= 1'b0;
        penable_o <= 1'b0;
    endtask : xfer
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        xfer(1'b0, a, 32'h0, q);
    endtask : rd
endmodule : hif_host_model

// ---- test_host_irq_fifo_rx_config_regs.sv ----
// self-checking bench of the host register group
`timescale 1ns/100ps
module test_host_irq_fifo_rx_config_regs;
    import hif_pkg::*;
    logic clk_sys_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic psel, penable, pwrite, pready, irq;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [31:0] events = 32'h0;  // status sources
    hif_levels_type levels = '0;
    logic dword_rd = 1'b0;
    logic pkt_start = 1'b0;
    hif_rxcfg_type rxcfg;
    logic [4:0] active_off;
    logic [2:0] pad;  // padding hint from the design
    int n_mismatch = 0;
    int n_compared = 0;
    hif_host_model host_u (.clk_sys_i(clk_sys_i), .psel_o(psel), .penable_o(penable),
        .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata), .prdata_i(prdata),
        .pready_i(pready));
    hif_regs dut_u (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(), .source_event_i(events),
        .levels_i(levels), .rx_dword_read_i(dword_rd), .rx_packet_start_i(pkt_start),
        .rxcfg_o(rxcfg), .active_offset_o(active_off), .pad_dwords_o(pad), .irq_o(irq));
    initial forever #10 clk_sys_i = ~clk_sys_i;
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            $display("unexpected %s expected %h seen %h", what, exp, got);
            n_mismatch++;
        end
    endtask : chk
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
        logic [31:0] d;
        host_u.rd(a, d);
        chk(what, exp, d);
    endtask : rd_chk
    // one-cycle doubleword read pulses from the receive datapath
    task automatic pulse(input int n);
        repeat (n) begin
            @(posedge clk_sys_i) dword_rd <= 1'b1;
            @(posedge clk_sys_i) dword_rd <= 1'b0;
        end
    endtask : pulse
    task automatic t_reset;
        chk("irq reset", 32'h0, {31'h0, irq});
        rd_chk(HIF_ADDR_MASK, 32'h0, "mask reset");
        rd_chk(HIF_ADDR_ORDER, 32'h8765_4321, "byte test");
        rd_chk(HIF_ADDR_FIFO_THR, 32'h4800_0000, "thresholds reset");
        rd_chk(HIF_ADDR_RXCONF, 32'h0, "rx config reset");
    endtask : t_reset
    task automatic t_regs;
        host_u.wr(HIF_ADDR_MASK, 32'hffff_ffff);
        rd_chk(HIF_ADDR_MASK, 32'h83bf_e7df, "mask bits");
        host_u.wr(HIF_ADDR_ORDER, 32'h0);
        host_u.wr(8'h00, 32'h1);
        rd_chk(HIF_ADDR_ORDER, 32'h8765_4321, "byte test kept");
        host_u.wr(HIF_ADDR_FIFO_THR, 32'hffff_ffff);
        rd_chk(HIF_ADDR_FIFO_THR, 32'hffff_00ff, "threshold bits");
        host_u.wr(HIF_ADDR_MASK, 32'h0);
    endtask : t_regs
    task automatic t_irq;
        @(posedge clk_sys_i) events <= 32'h8000_0000;
        @(posedge clk_sys_i) events <= 32'h0;
        @(negedge clk_sys_i);
        chk("irq masked", 32'h0, {31'h0, irq});
        rd_chk(HIF_ADDR_STATUS, 32'h8000_0000, "status");
        host_u.wr(HIF_ADDR_MASK, 32'h8000_0000);
        @(negedge clk_sys_i);
        chk("irq enabled", 32'h1, {31'h0, irq});
        host_u.wr(HIF_ADDR_INT_CLR, 32'h8000_0000);
        @(negedge clk_sys_i);
        chk("irq cleared", 32'h0, {31'h0, irq});
        rd_chk(HIF_ADDR_STATUS, 32'h0, "status cleared");
    endtask : t_irq
    task automatic t_levels;
        host_u.wr(HIF_ADDR_FIFO_THR, 32'h0203_0004);
        @(posedge clk_sys_i) levels <= '{16'd128, 8'd3, 8'd4};
        host_u.wr(HIF_ADDR_INT_CLR, 32'hffff_ffff);
        host_u.rd(HIF_ADDR_STATUS, rd);
        chk("levels at threshold", 32'h0, rd & 32'h288);
        @(posedge clk_sys_i) levels <= '{16'd192, 8'd4, 8'd5};
        repeat (2) @(posedge clk_sys_i);
        host_u.rd(HIF_ADDR_STATUS, rd);
        chk("tx space", 32'h200, rd & 32'h200);
        chk("tx status level", 32'h80, rd & 32'h80);
        chk("rx status level", 32'h8, rd & 32'h8);
        @(posedge clk_sys_i) levels <= '0;
    endtask : t_levels
    task automatic t_count;
        host_u.wr(HIF_ADDR_RXCONF, 32'h0003_0000);
        pulse(2);
        rd_chk(HIF_ADDR_RXCONF, 32'h0001_0000, "countdown");
        host_u.wr(HIF_ADDR_RXCONF, 32'h0002_8000);
        rd_chk(HIF_ADDR_RXCONF, 32'h0002_0000, "reload");
        pulse(2);
        repeat (2) @(posedge clk_sys_i);
        host_u.rd(HIF_ADDR_STATUS, rd);
        chk("countdown irq", 32'h0010_0000, rd & 32'h0010_0000);
    endtask : t_count
    // receiver idle and purged above, so the low offset bits may change once;
    // after that only the dword offset moves, each time taken up at the next doubleword read
    task automatic t_offset;
        logic [2:0] pad_exp [3] = '{3'd0, 3'd1, 3'd5};  // three words used: pad to 1, 4, 8
        logic [4:0] off;
        logic [2:0] prev_dw;
        prev_dw = 3'h0;
        @(posedge clk_sys_i) pkt_start <= 1'b1;
        @(posedge clk_sys_i) pkt_start <= 1'b0;
        levels <= '{16'd0, 8'd0, 8'd3};
        for (int i = 0; i < 3; i++) begin
            off = 5'((i + 5) * 4 + 2);  // low bits stay 2
            host_u.wr(HIF_ADDR_RXCONF, (i << 30) | (32'(off) << 8));
            @(negedge clk_sys_i);
            chk("align", i, {30'h0, rxcfg.align});
            chk("offset", 32'(off), {27'h0, rxcfg.start_offset});
            chk("dword offset held", 32'(prev_dw), {29'h0, active_off[4:2]});
            chk("pad words", 32'(pad_exp[i]), {29'h0, pad});
            pulse(1);
            @(negedge clk_sys_i);
            chk("active offset", 32'(off), {27'h0, active_off});
            prev_dw = off[4:2];
        end
        @(posedge clk_sys_i) levels <= '0;
    endtask : t_offset
    task automatic summarize;
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : summarize
    initial begin
        repeat (5) @(posedge clk_sys_i);
        reset_n_i <= 1'b1;
        t_reset();
        t_regs();
        t_irq();
        t_levels();
        t_count();
        t_offset();
        summarize();
    end
    // watchdog: the sequence needs about 115 cycles
    initial begin
        #400000;
        n_mismatch++;
        summarize();
    end
endmodule : test_host_irq_fifo_rx_config_regs
